// ==== hdl/lbs_defs.vh ====
// Purpose: Shared constants of the logic array block with memory mode
// Assumes: Included by bare name from the design file
// Notes:   Definitions only
`ifndef LBS_DEFS_VH
`define LBS_DEFS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LBS_A_CTRL    8'h00
`define LBS_A_STATUS  8'h04
`define LBS_A_NVADDR  8'h08
`define LBS_A_NVDATA  8'h0c
`define LBS_A_REGTYPE 8'h10
`define LBS_A_BYPASS  8'h14
`define LBS_A_CLKSRC  8'h18
`define LBS_A_CLKINV  8'h1c
`define LBS_A_ALLOCLO 8'h20
`define LBS_A_ALLOCHI 8'h24
`define LBS_A_CMP     8'h28
`define LBS_A_OESEL   8'h2c
`define LBS_A_PTSEL   8'h30
`define LBS_A_PTTRUE  8'h34
`define LBS_A_PTCOMP  8'h38
// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define LBS_CTRL_MEM   0
`define LBS_CTRL_SPLIT 1
`define LBS_CTRL_GSEL  2
`define LBS_RST_CTRL   3'h0
`define LBS_RST_MC     10'h000
`define LBS_RST_MC2    20'h00000
`define LBS_RST_INV    12'h000
`define LBS_RST_WORD   32'h00000000
`define LBS_RST_AHI    28'h0000000
`define LBS_RST_CMP    16'h0000
`define LBS_RST_SEL    7'h00
`define LBS_RST_SYNC   36'h000000000
`define LBS_INV_PRE    10
`define LBS_INV_CLR    11
// ----------------------------------------------------------------
// Memory-mode input field positions
// ----------------------------------------------------------------
`define LBS_IN_ADDR 0
`define LBS_IN_DATA 7
`define LBS_IN_BE   17
`define LBS_IN_WE   18
`define LBS_IN_OE   19
// ----------------------------------------------------------------
// Term and group layout
// ----------------------------------------------------------------
`define LBS_NUM_T   66
`define LBS_NUM_G   30
`define LBS_EXT_LO  20
`define LBS_EXT_HI  25
`define LBS_T_ACLK0 60
`define LBS_T_ACLK1 61
`define LBS_T_PRE   62
`define LBS_T_CLR   63
`define LBS_T_OE0   64
`define LBS_T_OE1   65
`define LBS_MC_LAST 4'd9
`define LBS_NO_MC   4'hf
`define LBS_ONE4    4'd1
// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define LBS_RT_D   2'h0
`define LBS_RT_T   2'h1
`define LBS_RT_JK  2'h2
`define LBS_RT_SR  2'h3
`define LBS_CS_GLB 2'h0
`define LBS_CS_DLY 2'h1
`define LBS_CS_AC0 2'h2
`define LBS_CS_AC1 2'h3
`define LBS_AL_HOME 2'h0
`define LBS_AL_DOWN 2'h1
`define LBS_AL_UP   2'h2
`define LBS_OE_OFF 2'h0
`define LBS_OE_ON  2'h1
`define LBS_OE_L0  2'h2
`define LBS_OE_L1  2'h3
`endif

// ==== hdl/lbs_logic_array_block.v ====
// Purpose: One logic array block, logic mode or 128x10 memory mode
// Assumes: One clock; pins and global clocks are asynchronous inputs
// Notes:   Configuration is written over APB
//
// Summary of operation
// RULE1: Block is ten macrocells or 128x10 memory
// RULE2: Takes 24 routing inputs and two clocks
// RULE3: Logic mode: macrocells, comparator, control terms
// RULE4: Two groups of two terms, borrow up
// RULE5: Register is D, T, JK, SR or bypassed
// RULE6: Global clock and two array clocks, invertible
// RULE7: Direct, delayed global or array clock modes
// RULE8: Term-driven preset and clear, invertible polarity
// RULE9: Twelve-pair compare routed to one macrocell
// RULE10: Memory data shared bus or split buses
// RULE11: Inputs: 7 address, 10 data, 3 controls
// RULE12: Block enable high: no cycle, drivers off
// RULE13: Write enable picks cycle, output enable drives
// RULE14: Memory loaded from nonvolatile copy at start
// RULE15: Memory keeps contents until written
// RULE16: Memory mode leaves no macrocell logic
// RULE17: Blocks cascade by user routing outside
// RULE18: Outputs feed the global routing array
// RULE19: Pin enable: local enable, on or off
// RULE20: Write on selected global clock rising edge
//
// Design decisions made here: register access over APB and the register addresses.
`include "lbs_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module lbs_logic_array_block #(
  parameter NMC   = 10,
  parameter NIN   = 24,
  parameter DEPTH = 128,
  parameter DW    = 10,
  parameter AW    = 7
) (
  input  wire              clock,
  input  wire              srst,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire [NIN-1:0]    rtIn,
  input  wire [1:0]        globalClk,
  output reg  [NMC-1:0]    rtOut,
  input  wire [NMC-1:0]    pinIn,
  output reg  [NMC-1:0]    pinOut,
  output reg  [NMC-1:0]    pinOeN
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [2:0]     ctrl;
  reg  [AW-1:0]  nvAddr;
  reg  [19:0]    regType;
  reg  [NMC-1:0] bypass;
  reg  [19:0]    clkSrc;
  reg  [11:0]    clkInv;
  reg  [31:0]    allocLo;
  reg  [27:0]    allocHi;
  reg  [15:0]    cmpCfg;
  reg  [19:0]    oeSel;
  reg  [6:0]     ptSel;
  reg  [23:0]    ptTrue [0:`LBS_NUM_T-1];
  reg  [23:0]    ptComp [0:`LBS_NUM_T-1];
  reg  [DW-1:0]  shadow [0:DEPTH-1];
  reg  [DW-1:0]  mem [0:DEPTH-1];
  reg  [35:0]    sync1;
  reg  [35:0]    sync2;
  reg  [35:0]    sync3;
  reg  [35:0]    filt;
  reg            gDel;
  reg            gPrev;
  reg  [NMC-1:0] clkPrev;
  reg  [NMC-1:0] q;
  reg  [DW-1:0]  rdData;
  reg            initBusy;
  reg  [AW-1:0]  initCnt;
  reg  [`LBS_NUM_T-1:0] termOut;
  reg  [NMC-1:0] sumA;
  reg  [NMC-1:0] sumB;
  reg  [NMC-1:0] clkSig;
  reg  [NMC-1:0] mcOut;
  reg  [NMC-1:0] oeCalc;
  reg  [3:0]     own;
  reg            grpSum;
  reg            cmpEq;
  reg  [31:0]    rdMux;
  reg            hit;
  integer        t;
  integer        g;
  integer        m;
  integer        mi;
  wire [NIN-1:0] fIn = filt[23:0];
  wire [NMC-1:0] fPin = filt[35:26];
  wire           memMode = ctrl[`LBS_CTRL_MEM];
  wire           gSel = filt[24 + ctrl[`LBS_CTRL_GSEL]];
  wire           gEdge = gSel & ~gPrev;
  wire [59:0]    alloc = {allocHi, allocLo};
  wire [AW-1:0]  mAddr = fIn[`LBS_IN_ADDR +: AW]; // see RULE11
  wire           beN = fIn[`LBS_IN_BE];
  wire           weN = fIn[`LBS_IN_WE];
  wire           oeN = fIn[`LBS_IN_OE];
  wire [DW-1:0]  wrData = ctrl[`LBS_CTRL_SPLIT] ?
                          fIn[`LBS_IN_DATA +: DW] : fPin; // see RULE10
  wire           preAct = termOut[`LBS_T_PRE] ^ clkInv[`LBS_INV_PRE];
  wire           clrAct = termOut[`LBS_T_CLR] ^ clkInv[`LBS_INV_CLR];
  wire           apbAcc = psel & penable;
  wire           wrEn = apbAcc & pready & pwrite & hit;
  wire           ptOk = ptSel < `LBS_NUM_T;

  // Owner of a term group; LBS_NO_MC when the group is unused
  function [3:0] grpOwner(input [4:0] gi, input [1:0] code);
    begin
      if (gi >= `LBS_EXT_HI) begin
        grpOwner = (code == `LBS_AL_HOME) ? `LBS_MC_LAST : `LBS_NO_MC;
      end else if (gi >= `LBS_EXT_LO) begin
        grpOwner = (code == `LBS_AL_HOME) ? 4'd0 : `LBS_NO_MC;
      end else if (!gi[0] || code == `LBS_AL_HOME) begin
        grpOwner = gi[4:1];
      end else if (code == `LBS_AL_DOWN && gi[4:1] != 4'd0) begin
        grpOwner = gi[4:1] - `LBS_ONE4;
      end else if (code == `LBS_AL_UP && gi[4:1] != `LBS_MC_LAST) begin
        grpOwner = gi[4:1] + `LBS_ONE4;
      end else begin
        grpOwner = `LBS_NO_MC;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Three stages; a bit moves once stages two and three agree
  always @(posedge clock) begin
    sync1 <= {pinIn, globalClk, rtIn}; // see RULE2
    sync2 <= sync1;
    sync3 <= sync2;
    if (srst) begin
      filt <= `LBS_RST_SYNC;
    end else begin
      filt <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
    end
  end

  // Global clock history and local delayed copy
  always @(posedge clock) begin
    if (srst) begin
      gDel    <= 1'b0;
      gPrev   <= 1'b0;
      clkPrev <= `LBS_RST_MC;
    end else begin
      gDel    <= gSel; // see RULE7
      gPrev   <= gSel;
      clkPrev <= clkSig;
    end
  end

  // ----------------------------------------------------------------
  // Logic mode combinational path
  // ----------------------------------------------------------------
  always @* begin
    // Product terms; a term with no literals is unused and reads 0
    for (t = 0; t < `LBS_NUM_T; t = t + 1) begin
      termOut[t] = (|(ptTrue[t] | ptComp[t])) &
                   (&(~ptTrue[t] | fIn)) &
                   (&(~ptComp[t] | ~fIn));
    end
    // Identity compare of low and high halves, masked per pair
    cmpEq = &(~cmpCfg[11:0] | ~(fIn[11:0] ^ fIn[23:12])); // see RULE9
    sumA = `LBS_RST_MC;
    sumB = `LBS_RST_MC;
    own  = `LBS_NO_MC;
    grpSum = 1'b0;
    // Group allocation; home group 2m is the A input, all others feed B
    for (g = 0; g < `LBS_NUM_G; g = g + 1) begin
      own = grpOwner(g[4:0], alloc[2*g +: 2]); // see RULE4
      grpSum = termOut[2*g] | termOut[2*g+1];
      for (m = 0; m < NMC; m = m + 1) begin
        if (own == m[3:0]) begin
          if (g == 2*m) begin
            sumA[m] = sumA[m] | grpSum;
          end else begin
            sumB[m] = sumB[m] | grpSum;
          end
        end
      end
    end
    for (m = 0; m < NMC; m = m + 1) begin
      if (cmpCfg[15:12] == m[3:0]) begin
        sumB[m] = sumB[m] | cmpEq; // see RULE9
      end
      // Clock source per register, true or inverted
      case (clkSrc[2*m +: 2])
        `LBS_CS_GLB: clkSig[m] = gSel;
        `LBS_CS_DLY: clkSig[m] = gDel;
        `LBS_CS_AC0: clkSig[m] = termOut[`LBS_T_ACLK0];
        `LBS_CS_AC1: clkSig[m] = termOut[`LBS_T_ACLK1];
        default:     clkSig[m] = gSel;
      endcase
      clkSig[m] = clkSig[m] ^ clkInv[m]; // see RULE6
      mcOut[m] = bypass[m] ? (sumA[m] | sumB[m]) : q[m]; // see RULE5
      // Pin enable from local enables or fixed level
      case (oeSel[2*m +: 2])
        `LBS_OE_OFF: oeCalc[m] = 1'b0;
        `LBS_OE_ON:  oeCalc[m] = 1'b1;
        `LBS_OE_L0:  oeCalc[m] = termOut[`LBS_T_OE0];
        `LBS_OE_L1:  oeCalc[m] = termOut[`LBS_T_OE1];
        default:     oeCalc[m] = 1'b0;
      endcase // see RULE19
    end
  end

  // ----------------------------------------------------------------
  // Macrocell registers
  // ----------------------------------------------------------------
  // Clear beats preset; both beat the clock edge
  always @(posedge clock) begin
    if (srst || memMode) begin
      q <= `LBS_RST_MC; // see RULE16
    end else begin
      for (mi = 0; mi < NMC; mi = mi + 1) begin
        if (clrAct) begin
          q[mi] <= 1'b0; // see RULE8
        end else if (preAct) begin
          q[mi] <= 1'b1;
        end else if (clkSig[mi] & ~clkPrev[mi]) begin
          case (regType[2*mi +: 2])
            `LBS_RT_D:  q[mi] <= sumA[mi] | sumB[mi];
            `LBS_RT_T:  q[mi] <= q[mi] ^ (sumA[mi] | sumB[mi]);
            `LBS_RT_JK: q[mi] <= (sumA[mi] & ~q[mi]) | (~sumB[mi] & q[mi]);
            `LBS_RT_SR: q[mi] <= sumA[mi] | (~sumB[mi] & q[mi]);
            default:    q[mi] <= q[mi];
          endcase // see RULE5
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory mode
  // ----------------------------------------------------------------
  // Start-up copy sequencer
  always @(posedge clock) begin
    if (srst) begin
      initBusy <= 1'b1;
      initCnt  <= {AW{1'b0}};
    end else if (initBusy) begin
      initCnt <= initCnt + {{(AW-1){1'b0}}, 1'b1};
      if (&initCnt) begin
        initBusy <= 1'b0;
      end
    end
  end

  // Array: start-up copy, then user writes only
  always @(posedge clock) begin
    if (initBusy) begin
      mem[initCnt] <= shadow[initCnt]; // see RULE14
    end else if (memMode && gEdge && !beN && !weN) begin
      mem[mAddr] <= wrData; // see RULE20, RULE15
    end
  end

  // Read port; follows the address while a read cycle is selected
  always @(posedge clock) begin
    if (srst) begin
      rdData <= `LBS_RST_MC;
    end else if (memMode && !initBusy && !beN && weN) begin
      rdData <= mem[mAddr]; // see RULE12, RULE13
    end
  end

  // ----------------------------------------------------------------
  // Block outputs
  // ----------------------------------------------------------------
  // Routing array and pins, chosen by mode
  always @(posedge clock) begin
    if (srst) begin
      rtOut  <= `LBS_RST_MC;
      pinOut <= `LBS_RST_MC;
      pinOeN <= ~`LBS_RST_MC;
    end else if (memMode) begin
      rtOut  <= rdData; // see RULE1, RULE18, RULE17
      pinOut <= rdData;
      pinOeN <= {NMC{initBusy | beN | oeN}}; // see RULE12, RULE13
    end else begin
      rtOut  <= mcOut; // see RULE18, RULE3
      pinOut <= mcOut;
      pinOeN <= ~oeCalc;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Address decode and read mux
  always @* begin
    hit   = 1'b1;
    rdMux = `LBS_RST_WORD;
    case (paddr)
      `LBS_A_CTRL:    rdMux[2:0] = ctrl;
      `LBS_A_STATUS:  rdMux[11:0] = {q, cmpEq, initBusy};
      `LBS_A_NVADDR:  rdMux[AW-1:0] = nvAddr;
      `LBS_A_NVDATA:  rdMux[DW-1:0] = shadow[nvAddr];
      `LBS_A_REGTYPE: rdMux[19:0] = regType;
      `LBS_A_BYPASS:  rdMux[NMC-1:0] = bypass;
      `LBS_A_CLKSRC:  rdMux[19:0] = clkSrc;
      `LBS_A_CLKINV:  rdMux[11:0] = clkInv;
      `LBS_A_ALLOCLO: rdMux = allocLo;
      `LBS_A_ALLOCHI: rdMux[27:0] = allocHi;
      `LBS_A_CMP:     rdMux[15:0] = cmpCfg;
      `LBS_A_OESEL:   rdMux[19:0] = oeSel;
      `LBS_A_PTSEL:   rdMux[6:0] = ptSel;
      `LBS_A_PTTRUE:  rdMux[23:0] = ptOk ? ptTrue[ptSel] : 24'h000000;
      `LBS_A_PTCOMP:  rdMux[23:0] = ptOk ? ptComp[ptSel] : 24'h000000;
      default:        hit = 1'b0;
    endcase
  end

  // Answer one cycle into the access phase
  always @(posedge clock) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `LBS_RST_WORD;
    end else begin
      pready  <= apbAcc & ~pready;
      pslverr <= apbAcc & ~pready & ~hit; // Error stands with pready only
      if (apbAcc && !pready) begin
        prdata  <= (hit && !pwrite) ? rdMux : `LBS_RST_WORD;
      end
    end
  end

  // Configuration registers
  always @(posedge clock) begin
    if (srst) begin
      ctrl    <= `LBS_RST_CTRL;
      nvAddr  <= {AW{1'b0}};
      regType <= `LBS_RST_MC2;
      bypass  <= `LBS_RST_MC;
      clkSrc  <= `LBS_RST_MC2;
      clkInv  <= `LBS_RST_INV;
      allocLo <= `LBS_RST_WORD;
      allocHi <= `LBS_RST_AHI;
      cmpCfg  <= `LBS_RST_CMP;
      oeSel   <= `LBS_RST_MC2;
      ptSel   <= `LBS_RST_SEL;
    end else if (wrEn) begin
      case (paddr)
        `LBS_A_CTRL:    ctrl <= pwdata[2:0]; // see RULE1
        `LBS_A_NVADDR:  nvAddr <= pwdata[AW-1:0];
        `LBS_A_NVDATA:  nvAddr <= nvAddr + {{(AW-1){1'b0}}, 1'b1};
        `LBS_A_REGTYPE: regType <= pwdata[19:0];
        `LBS_A_BYPASS:  bypass <= pwdata[NMC-1:0];
        `LBS_A_CLKSRC:  clkSrc <= pwdata[19:0];
        `LBS_A_CLKINV:  clkInv <= pwdata[11:0];
        `LBS_A_ALLOCLO: allocLo <= pwdata;
        `LBS_A_ALLOCHI: allocHi <= pwdata[27:0];
        `LBS_A_CMP:     cmpCfg <= pwdata[15:0];
        `LBS_A_OESEL:   oeSel <= pwdata[19:0];
        `LBS_A_PTSEL:   ptSel <= pwdata[6:0];
        default:        ctrl <= ctrl;
      endcase
    end
  end

  // Term masks and nonvolatile image; kept across reset
  always @(posedge clock) begin
    if (wrEn && paddr == `LBS_A_NVDATA) begin
      shadow[nvAddr] <= pwdata[DW-1:0];
    end
    if (wrEn && ptOk && paddr == `LBS_A_PTTRUE) begin
      ptTrue[ptSel] <= pwdata[23:0];
    end
    if (wrEn && ptOk && paddr == `LBS_A_PTCOMP) begin
      ptComp[ptSel] <= pwdata[23:0];
    end
  end
endmodule // lbs_logic_array_block
`default_nettype wire

// ==== test/lbs_far_side.sv ====
// Purpose: User logic on the routing array and pin side
// Assumes: Commanded by the bench through its tasks
// Notes:   A driven pin shows the block's level, else ours
`timescale 1ns/10ps
`default_nettype none
module lbs_far_side (
  input  wire logic        clock,
  input  wire logic [9:0]  pinOut,
  input  wire logic [9:0]  pinOeN,
  output var  logic [23:0] rtIn,
  output var  logic [1:0]  globalClk,
  output wire logic [9:0]  pinIn
);
  logic [9:0] pinDrv;
  // Wire level from the block's enable alone
  assign pinIn = (pinOut & ~pinOeN) | (pinDrv & pinOeN);
  initial begin
    rtIn = 24'h0e0000;
    globalClk = 2'h0;
    pinDrv = 10'h000;
  end
  // Memory-mode field packing
  task automatic setMem(input logic [6:0] a, input logic [9:0] d,
                        input logic be, input logic we, input logic oe);
    @(posedge clock);
    rtIn <= {4'h0, oe, we, be, d, a};
    pinDrv <= d;
  endtask
  // Raw routing inputs for logic mode
  task automatic setRaw(input logic [23:0] v);
    @(posedge clock);
    rtIn <= v;
  endtask
  // One rising edge of a global clock, slow against sync
  task automatic strobe(input logic k);
    repeat (6) @(posedge clock);
    globalClk[k] <= 1'b1;
    repeat (6) @(posedge clock);
    globalClk[k] <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
endmodule // lbs_far_side
`default_nettype wire

// ==== test/lbs_logic_array_block_asserts.sv ====
// Purpose: Concurrent checks on the block's bus and pin ports
// Assumes: One clock domain, srst synchronous active high
// Notes:   Attached by bind after the module
`timescale 1ns/10ps
`default_nettype none
module lbs_logic_array_block_asserts #(
  parameter NMC = 10
) (
  input wire logic           clock,
  input wire logic           srst,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic [NMC-1:0] rtOut,
  input wire logic [NMC-1:0] pinOut,
  input wire logic [NMC-1:0] pinOeN
);
  // --------------------------------------------------------------
  // Bus answer timing and reset state
  // --------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  a_setup_quiet: assert property (psel && !penable |=> !pready)
    else $error("pready in first access cycle");
  a_idle_quiet: assert property (!psel |=> !pready)
    else $error("pready without a selected access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside an answer");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write answer");
  a_rst_pins: assert property ($past(srst) |->
    pinOeN == {NMC{1'b1}} && rtOut == '0 && pinOut == '0)
    else $error("outputs not released after reset");
endmodule // lbs_logic_array_block_asserts
bind lbs_logic_array_block lbs_logic_array_block_asserts #(.NMC(NMC)) chk (
  .clock(clock), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rtOut(rtOut), .pinOut(pinOut), .pinOeN(pinOeN));
`default_nettype wire

// ==== test/tb_logic_array_block.sv ====
// Purpose: Self-checking bench for the logic array block
// Assumes: APB master tasks, far side commanded by tasks
// Notes:   Memory inputs pass a sync pipeline before use
`include "lbs_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_logic_array_block;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] q;
  logic        e;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [23:0] rtIn;
  wire  [1:0]  globalClk;
  wire  [9:0]  rtOut, pinIn, pinOut, pinOeN;
  int          errTotal = 0;
  int          nChecks = 0;
  int          cyc = 0;
  always #10 clock = ~clock;
  lbs_logic_array_block dut (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rtIn(rtIn),
    .globalClk(globalClk), .rtOut(rtOut), .pinIn(pinIn),
    .pinOut(pinOut), .pinOeN(pinOeN));
  lbs_far_side far (.clock(clock), .pinOut(pinOut), .pinOeN(pinOeN),
    .rtIn(rtIn), .globalClk(globalClk), .pinIn(pinIn));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic closeOut();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    nChecks++;
    if (g !== x) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    er = pslverr;
    if (n >= 50) errTotal++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, q, e);
  endtask
  // Read one word and compare what reaches the routing array
  task automatic memRd(input logic [6:0] a, input logic [9:0] x);
    far.setMem(a, 10'h000, 1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge clock);
    chk("rtOut", 32'(x), 32'(rtOut));
  endtask
  function automatic logic [9:0] nv(input int k);
    return 10'h155 ^ k[9:0];
  endfunction
  // Run length guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      closeOut();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rd(`LBS_A_STATUS);
    chk("initBusy", 32'h1, q & 32'h1);
    rd(`LBS_A_CTRL);
    chk("ctrl", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("pslverr", 32'h1, 32'(e));
    wr(`LBS_A_NVADDR, 32'h0);
    chk("pslverrOk", 32'h0, 32'(e));
    for (int k = 0; k < 4; k++) wr(`LBS_A_NVDATA, 32'(nv(k)));
    rd(`LBS_A_NVADDR);
    chk("nvAddr", 32'h4, q);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    for (int n = 0; n < 100; n++) begin
      rd(`LBS_A_STATUS);
      if (q[0] === 1'b0) break;
    end
    chk("initDone", 32'h0, q & 32'h1);
    wr(`LBS_A_CTRL, 32'h3);
    for (int k = 0; k < 4; k++) memRd(k[6:0], nv(k));
    rd(`LBS_A_STATUS);
    chk("mcRegs", 32'h0, (q >> 2) & 32'h3ff);
    far.setMem(7'd5, 10'h2c3, 1'b0, 1'b0, 1'b1);
    far.strobe(1'b0);
    memRd(7'd5, 10'h2c3);
    memRd(7'd1, nv(1));
    far.setMem(7'd5, 10'h0f0, 1'b1, 1'b0, 1'b0);
    far.strobe(1'b0);
    chk("pinOeN", 32'h3ff, 32'(pinOeN));
    memRd(7'd5, 10'h2c3);
    far.setMem(7'd5, 10'h000, 1'b0, 1'b1, 1'b0);
    repeat (8) @(posedge clock);
    chk("pinOeN", 32'h0, 32'(pinOeN));
    chk("pinOut", 32'h2c3, 32'(pinOut));
    far.setMem(7'd5, 10'h000, 1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge clock);
    chk("pinOeN", 32'h3ff, 32'(pinOeN));
    wr(`LBS_A_CTRL, 32'h5);
    far.setMem(7'd6, 10'h13c, 1'b0, 1'b0, 1'b1);
    far.strobe(1'b1);
    memRd(7'd6, 10'h13c);
    wr(`LBS_A_CTRL, 32'h0);
    wr(`LBS_A_CMP, 32'h0000ffff);
    far.setRaw(24'habcabc);
    repeat (8) @(posedge clock);
    rd(`LBS_A_STATUS);
    chk("cmpEq", 32'h1, (q >> 1) & 32'h1);
    far.setRaw(24'habcabd);
    repeat (8) @(posedge clock);
    rd(`LBS_A_STATUS);
    chk("cmpNe", 32'h0, (q >> 1) & 32'h1);
    // Logic mode: clear every term mask, then build up one macrocell
    for (int p = 0; p < `LBS_NUM_T; p++) begin
      wr(`LBS_A_PTSEL, 32'(p));
      wr(`LBS_A_PTTRUE, 32'h0);
      wr(`LBS_A_PTCOMP, 32'h0);
    end
    wr(`LBS_A_PTSEL, 32'h0);
    wr(`LBS_A_PTTRUE, 32'h1);
    wr(`LBS_A_BYPASS, 32'h1);
    far.setRaw(24'h000001);
    repeat (8) @(posedge clock);
    chk("mcComb", 32'h1, 32'(rtOut[0]));
    wr(`LBS_A_PTSEL, 32'h6);
    wr(`LBS_A_PTTRUE, 32'h2);
    wr(`LBS_A_ALLOCLO, 32'h40);
    far.setRaw(24'h000002);
    repeat (8) @(posedge clock);
    chk("mcBorrow", 32'h1, 32'(rtOut[0]));
    wr(`LBS_A_BYPASS, 32'h0);
    far.setRaw(24'h000001);
    repeat (8) @(posedge clock);
    chk("mcHold", 32'h0, 32'(rtOut[0]));
    far.strobe(1'b0);
    chk("mcReg", 32'h1, 32'(rtOut[0]));
    wr(`LBS_A_PTSEL, 32'(`LBS_T_CLR));
    wr(`LBS_A_PTTRUE, 32'h4);
    far.setRaw(24'h000005);
    repeat (8) @(posedge clock);
    chk("mcClear", 32'h0, 32'(rtOut[0]));
    closeOut();
  end
endmodule // tb_logic_array_block
`default_nettype wire
